// ==== inc/dds_pins_pkg.sv ====
// Constants shared by the DDS control-pin block and its buffer memory.
// Assumes one core clock domain; pin inputs arrive asynchronously.
package dds_pins_pkg;

  // Serial register file geometry
  localparam int REG_COUNT = 8;
  localparam int REG_WIDTH = 8;
  localparam int REG_AW = 3;

  // Serial register addresses
  localparam logic [2:0] SER_ADDR_AMP = 3'h0;
  localparam logic [2:0] SER_ADDR_FREQ0 = 3'h1;

  // Serial instruction layout
  localparam int INSTR_RW_BIT = 7;
  localparam int SER_BITS = 8;

  // Bus register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_OUTPUT = 8'h08;
  localparam logic [7:0] OFS_ACTIVE_LO = 8'h0c;
  localparam logic [7:0] OFS_ACTIVE_HI = 8'h10;

  // Control register fields
  localparam int CTRL_THREE_WIRE = 0;
  localparam int CTRL_LSB_FIRST = 1;
  localparam int CTRL_KEY_EN = 2;
  localparam int CTRL_PD_LO = 3;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Pacing clock is the core clock divided by four
  localparam int PACE_DIV_W = 2;
  localparam logic [1:0] PACE_PRE_RISE = 2'h1;

  // Latency from update to output, in core clock cycles
  localparam int FREQ_LAT_CYC = 24;
  localparam int AMP_LAT_CYC = 16;
  localparam int LAT_W = 5;

  // Synchronised pin vector layout
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_SDIO = 2;
  localparam int PIN_ABORT = 3;
  localparam int PIN_UPDATE = 4;
  localparam int PIN_PS_LO = 5;
  localparam int PIN_PS_HI = 6;
  localparam int PIN_KEY = 7;
  localparam int PIN_OSC = 8;
  localparam int PIN_PD = 9;
  localparam int PIN_ALIGN = 10;
  localparam int PIN_COUNT = 11;

  // Power-down states
  typedef enum logic [1:0] {PD_NONE, PD_RAPID, PD_SLEEP, PD_FULL} pd_state_t;

endpackage

// ==== rtl/dds_ctrl_pins.sv ====
// Control-pin front end of a direct digital synthesiser: serial port,
// update strobe, profile select, pacing clock and miscellaneous pins.
// Assumes clk_i is the core clock; every pin is asynchronous to it.
//
// Contract
// - Update strobe rising edge copies the whole buffer into active registers.
// - Oscillator select high enables oscillator; low bypasses it.
// - Hardware reset high forces all registers and state to initial values.
// - Abort high ends any serial transfer; new one only after it falls.
// - Three-wire mode drives read data on dedicated output; two-wire leaves it.
// - Three-wire: data pin input only; two-wire: data pin bidirectional.
// - Serial transfers happen only while active-low select is asserted.
// - Device outputs a pacing clock for strobe, profile and keying timing.
// - Alignment input, fed from a master pacing clock, realigns our timing.
// - Keying direction sampled on pacing clock when enabled; else held low.
// - Two profile-select inputs pick one of four, sampled on pacing clock.
// - Any profile-select change performs the same update as the strobe.
// - Power-down pin enters the configured power-down state.
// - New frequency reaches output 24 core cycles after an update.
// - New amplitude reaches output 16 core cycles after an update.
// - Serial transfers run most or least significant bit first, as set.
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module dds_ctrl_pins
  import dds_pins_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial port pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_n_o,
  output logic serial_read_out_o,
  input wire logic serial_port_abort_i,
  // Update, profile and keying pins
  input wire logic io_update_i,
  input wire logic profile_select_lo_i,
  input wire logic profile_select_hi_i,
  input wire logic keying_direction_i,
  // Clocking pins
  output logic sync_clk_o,
  input wire logic sync_align_i,
  input wire logic oscillator_select_pin_i,
  output logic osc_enable_o,
  output logic osc_bypass_o,
  // Power-down pin
  input wire logic ext_powerdown_pin_i,
  output logic [1:0] powerdown_o,
  // Core-facing results
  output logic [1:0] profile_o,
  output logic keying_dir_o,
  output logic [7:0] freq_word_o,
  output logic [7:0] amp_word_o
);

  typedef enum logic [1:0] {SP_IDLE, SP_INSTR, SP_DATA, SP_WAIT} sp_state_t;

  logic [PIN_COUNT-1:0] pin_meta_r, pin_r, pin_prev_r;
  logic [4:0] ctrl_r;
  logic [PACE_DIV_W-1:0] div_r;
  logic [1:0] prof_r, prof_new;
  logic upd_evt, pace_tick, sclk_rise, sclk_fall, sp_kill;
  sp_state_t sp_state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] rx_r, tx_r, rx_nxt, buf_rd_data;
  logic rd_mode_r, tx_load_r, buf_wr;
  logic [REG_AW-1:0] addr_r;
  logic [REG_COUNT*REG_WIDTH-1:0] buf_all, active_r;
  logic [7:0] freq_pend_r, amp_pend_r;
  logic [LAT_W-1:0] freq_cnt_r, amp_cnt_r;

  ////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for every pin; stage one feeds stage two only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_r <= '0;
      pin_r <= '0;
      pin_prev_r <= '0;
    end else begin
      pin_meta_r <= {sync_align_i, ext_powerdown_pin_i, oscillator_select_pin_i,
                     keying_direction_i, profile_select_hi_i, profile_select_lo_i,
                     io_update_i, serial_port_abort_i, sdio_i, cs_n_i, sclk_i};
      pin_r <= pin_meta_r;
      pin_prev_r <= pin_r;
    end
  end

  assign sclk_rise = pin_r[PIN_SCLK] & ~pin_prev_r[PIN_SCLK];
  assign sclk_fall = ~pin_r[PIN_SCLK] & pin_prev_r[PIN_SCLK];
  // Abort or deselect drops the serial engine at once
  assign sp_kill = pin_r[PIN_ABORT] | pin_r[PIN_CS_N];

  ////////////////////////////////////////////////////////////////////
  // Wishbone slave: one-cycle registered ack, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      ctrl_r <= CTRL_RESET;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_CTRL) begin
          ctrl_r <= wb_dat_i[4:0];
        end
        unique case (wb_adr_i)
          OFS_CTRL: wb_dat_o <= {27'h0, ctrl_r};
          OFS_STATUS: wb_dat_o <= {24'h0, sp_state_r == SP_IDLE ? 1'b0 : 1'b1,
                                   pin_r[PIN_ABORT], osc_enable_o, keying_dir_o,
                                   powerdown_o, profile_o};
          OFS_OUTPUT: wb_dat_o <= {16'h0, amp_word_o, freq_word_o};
          OFS_ACTIVE_LO: wb_dat_o <= active_r[31:0];
          OFS_ACTIVE_HI: wb_dat_o <= active_r[63:32];
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pacing clock: core clock over four, phase reset by the align input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= '0;
      sync_clk_o <= 1'b0;
    end else if (pin_r[PIN_ALIGN] && !pin_prev_r[PIN_ALIGN]) begin
      div_r <= '0;
      sync_clk_o <= 1'b0;
    end else begin
      div_r <= div_r + 1'b1;
      sync_clk_o <= div_r == PACE_PRE_RISE;
      if (div_r == PACE_PRE_RISE + 2'h1) begin
        sync_clk_o <= 1'b1;
      end
    end
  end

  // Sample point one core cycle before the pacing clock rises
  assign pace_tick = div_r == PACE_PRE_RISE;
  assign prof_new = {pin_r[PIN_PS_HI], pin_r[PIN_PS_LO]};

  ////////////////////////////////////////////////////////////////////
  // Profile and keying capture on the pacing clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prof_r <= '0;
      keying_dir_o <= 1'b0;
    end else if (pace_tick) begin
      prof_r <= prof_new;
      keying_dir_o <= ctrl_r[CTRL_KEY_EN] & pin_r[PIN_KEY];
    end
  end

  assign profile_o = prof_r;
  // Strobe edge or profile change both move the buffer across
  assign upd_evt = (pin_r[PIN_UPDATE] & ~pin_prev_r[PIN_UPDATE])
                 | (pace_tick & (prof_new != prof_r));

  ////////////////////////////////////////////////////////////////////
  // Oscillator and power-down pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_enable_o <= 1'b0;
      osc_bypass_o <= 1'b1;
      powerdown_o <= PD_NONE;
    end else begin
      osc_enable_o <= pin_r[PIN_OSC];
      osc_bypass_o <= ~pin_r[PIN_OSC];
      powerdown_o <= pin_r[PIN_PD] ? ctrl_r[CTRL_PD_LO +: 2] : PD_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Serial engine: instruction byte then one data byte
  always_comb begin
    if (ctrl_r[CTRL_LSB_FIRST]) begin
      rx_nxt = {pin_r[PIN_SDIO], rx_r[7:1]};
    end else begin
      rx_nxt = {rx_r[6:0], pin_r[PIN_SDIO]};
    end
  end

  assign buf_wr = sp_state_r == SP_DATA && !rd_mode_r && sclk_rise && !sp_kill
                && bit_cnt_r == 4'(SER_BITS - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i || sp_kill) begin
      sp_state_r <= SP_IDLE;
      bit_cnt_r <= '0;
      rx_r <= '0;
      rd_mode_r <= 1'b0;
      addr_r <= '0;
    end else begin
      unique case (sp_state_r)
        SP_IDLE: begin
          sp_state_r <= SP_INSTR;
          bit_cnt_r <= '0;
        end
        SP_INSTR: begin
          if (sclk_rise) begin
            rx_r <= rx_nxt;
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'(SER_BITS - 1)) begin
              rd_mode_r <= rx_nxt[INSTR_RW_BIT];
              addr_r <= rx_nxt[REG_AW-1:0];
              bit_cnt_r <= '0;
              sp_state_r <= SP_DATA;
            end
          end
        end
        SP_DATA: begin
          if (sclk_rise) begin
            rx_r <= rx_nxt;
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'(SER_BITS - 1)) begin
              sp_state_r <= SP_WAIT;
            end
          end
        end
        SP_WAIT: sp_state_r <= SP_WAIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data shifter, driven on falling serial clock edges
  always_ff @(posedge clk_i) begin
    if (rst_i || sp_kill) begin
      tx_r <= '0;
      tx_load_r <= 1'b0;
      sdio_o <= 1'b0;
      sdio_oe_n_o <= 1'b1;
      serial_read_out_o <= 1'b0;
    end else begin
      // Buffer read data lands one cycle after the address is known
      tx_load_r <= sp_state_r == SP_INSTR && sclk_rise && bit_cnt_r == 4'(SER_BITS - 1);
      if (tx_load_r) begin
        tx_r <= buf_rd_data;
      end else if (sp_state_r == SP_DATA && rd_mode_r && sclk_fall) begin
        if (ctrl_r[CTRL_LSB_FIRST]) begin
          sdio_o <= tx_r[0];
          serial_read_out_o <= ctrl_r[CTRL_THREE_WIRE] & tx_r[0];
          tx_r <= {1'b0, tx_r[7:1]};
        end else begin
          sdio_o <= tx_r[7];
          serial_read_out_o <= ctrl_r[CTRL_THREE_WIRE] & tx_r[7];
          tx_r <= {tx_r[6:0], 1'b0};
        end
        // Three-wire keeps the data pin an input; two-wire turns it round
        sdio_oe_n_o <= ctrl_r[CTRL_THREE_WIRE];
      end else if (sp_state_r == SP_WAIT) begin
        sdio_oe_n_o <= 1'b1;
      end
    end
  end

  reg_buffer #(
    .DEPTH(REG_COUNT),
    .WIDTH(REG_WIDTH),
    .AW(REG_AW)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(buf_wr),
    .wr_addr_i(addr_r),
    .wr_data_i(rx_nxt),
    .rd_addr_i(rx_nxt[REG_AW-1:0]),
    .rd_data_o(buf_rd_data),
    .contents_o(buf_all)
  );

  ////////////////////////////////////////////////////////////////////
  // Active registers take the whole buffer on every update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_r <= '0;
    end else if (upd_evt) begin
      active_r <= buf_all;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output latency: a later update restarts the count, so the newest wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_pend_r <= '0;
      freq_cnt_r <= '0;
      freq_word_o <= '0;
    end else if (upd_evt) begin
      freq_pend_r <= buf_all[(int'(SER_ADDR_FREQ0) + int'(pace_tick ? prof_new : prof_r))
                             * REG_WIDTH +: REG_WIDTH];
      freq_cnt_r <= LAT_W'(FREQ_LAT_CYC);
    end else if (freq_cnt_r != '0) begin
      freq_cnt_r <= freq_cnt_r - 1'b1;
      if (freq_cnt_r == LAT_W'(1)) begin
        freq_word_o <= freq_pend_r;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amp_pend_r <= '0;
      amp_cnt_r <= '0;
      amp_word_o <= '0;
    end else if (upd_evt) begin
      amp_pend_r <= buf_all[int'(SER_ADDR_AMP) * REG_WIDTH +: REG_WIDTH];
      amp_cnt_r <= LAT_W'(AMP_LAT_CYC);
    end else if (amp_cnt_r != '0) begin
      amp_cnt_r <= amp_cnt_r - 1'b1;
      if (amp_cnt_r == LAT_W'(1)) begin
        amp_word_o <= amp_pend_r;
      end
    end
  end

endmodule

// ==== rtl/reg_buffer.sv ====
// Buffer memory for the serial register file: one write port, one
// registered read port, and all entries in parallel for a bulk copy.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module reg_buffer #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 8,
  parameter int AW = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // Read port
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o,
  // Whole contents for the update copy
  output logic [DEPTH*WIDTH-1:0] contents_o
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  ////////////////////////////////////////////////////////////////////
  // Storage, one entry per generate step
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mem_r[g] <= '0;
        end else if (wr_en_i && wr_addr_i == AW'(g)) begin
          mem_r[g] <= wr_data_i;
        end
      end
      assign contents_o[g*WIDTH +: WIDTH] = mem_r[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Registered read, one cycle after the address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem_r[rd_addr_i];
    end
  end

endmodule

// ==== test/dds_ctrl_pins_asserts.sv ====
// Port checker for the DDS control-pin block.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
module dds_ctrl_pins_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic serial_port_abort_i,
  input wire logic sdio_oe_n_o,
  // Other pins and results
  input wire logic profile_select_lo_i,
  input wire logic profile_select_hi_i,
  input wire logic [1:0] profile_o,
  input wire logic keying_direction_i,
  input wire logic keying_dir_o,
  input wire logic oscillator_select_pin_i,
  input wire logic osc_enable_o,
  input wire logic osc_bypass_o,
  input wire logic ext_powerdown_pin_i,
  input wire logic [1:0] powerdown_o,
  input wire logic sync_clk_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // Bus request and its one-cycle answer
  sequence wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_one_cycle: assert property (wb_req |=> ack_pulse)
    else $error("bus answer late or long");
  a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("bus answer without request");
  // Reset state, judged while reset is held
  a_reset_state: assert property (disable iff (1'b0)
    rst_i |=> sdio_oe_n_o && osc_bypass_o && !osc_enable_o && !sync_clk_o && !wb_ack_o)
    else $error("reset state wrong");
  // Pins settle through two flops and a register
  a_osc_follow: assert property (
    $stable(oscillator_select_pin_i)[*5] |-> osc_enable_o == oscillator_select_pin_i
      && osc_bypass_o != oscillator_select_pin_i)
    else $error("oscillator outputs wrong");
  a_pd_released: assert property ((!ext_powerdown_pin_i)[*5] |-> powerdown_o == 2'h0)
    else $error("power-down without pin");
  a_idle_release: assert property (cs_n_i[*5] |-> sdio_oe_n_o)
    else $error("data pin driven unselected");
  a_abort_release: assert property (serial_port_abort_i[*5] |-> sdio_oe_n_o)
    else $error("data pin driven in abort");
  a_key_low: assert property ((!keying_direction_i)[*8] |-> !keying_dir_o)
    else $error("keying high with pin low");
  a_profile_track: assert property (
    $stable({profile_select_hi_i, profile_select_lo_i})[*8]
      |-> profile_o == {profile_select_hi_i, profile_select_lo_i})
    else $error("profile not sampled");
endmodule
bind dds_ctrl_pins dds_ctrl_pins_asserts chk_u (.*);

// ==== test/dds_ctrl_pins_tb_top.sv ====
// Bench for the DDS control-pin block: bus, serial link and pins.
// Assumes the host model on the serial pins and a 20 MHz core clock.
`timescale 1ns/1ps
module dds_ctrl_pins_tb_top;
  import dds_pins_pkg::*;
  // Inputs, all valued at time zero
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic sclk_i, cs_n_i, sdio_i, h_sd, h_en;
  logic idle_t = 1'b0;
  logic serial_port_abort_i = 1'b0;
  logic io_update_i = 1'b0;
  logic profile_select_lo_i = 1'b0;
  logic profile_select_hi_i = 1'b0;
  logic keying_direction_i = 1'b0;
  logic sync_align_i = 1'b0;
  logic oscillator_select_pin_i = 1'b0;
  logic ext_powerdown_pin_i = 1'b0;
  // Outputs
  logic [31:0] wb_dat_o, wb_q;
  logic wb_ack_o, sdio_o, sdio_oe_n_o, serial_read_out_o, sync_clk_o;
  logic osc_enable_o, osc_bypass_o, keying_dir_o;
  logic [1:0] powerdown_o, profile_o;
  logic [7:0] freq_word_o, amp_word_o, r;
  logic d;
  int fail_count = 0;
  int n_compared = 0;
  int sro_cnt = 0;
  // Block and host
  dds_ctrl_pins dut_u (.*);
  host_model host_u (.clk_i, .sclk_o(sclk_i), .cs_n_o(cs_n_i), .sd_o(h_sd),
    .sd_en_o(h_en), .sd_i(sdio_i), .sro_i(serial_read_out_o), .oe_n_i(sdio_oe_n_o));
  // Released wire toggles, so a stale bit never passes
  always @(posedge clk_i) idle_t <= !idle_t;
  // Core cycles with the dedicated read pin high; two-wire reads must add none
  always @(posedge clk_i) if (serial_read_out_o === 1'b1) sro_cnt <= sro_cnt + 1;
  assign sdio_i = (sdio_oe_n_o === 1'b0) ? sdio_o : (h_en ? h_sd : idle_t);
  always #25 clk_i = !clk_i;
  ////////////////////////////////////////
  // Verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Classic bus cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dt);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= dt;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      report_and_stop();
    end
    wb_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Step to a pacing clock rise
  task automatic pace;
    logic p;
    p = sync_clk_o;
    for (int i = 0; i < 8 && !(sync_clk_o === 1'b1 && p === 1'b0); i++) begin
      p = sync_clk_o;
      @(posedge clk_i);
    end
    chk("pace", 1, sync_clk_o);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    wb(1'b0, OFS_CTRL, 0);
    chk("ctrl", 0, wb_q);
    wb(1'b1, 8'h20, 32'hffffffff);
    wb(1'b1, OFS_OUTPUT, 32'h1234);
    wb(1'b0, OFS_OUTPUT, 0);
    chk("output", 0, wb_q);
    oscillator_select_pin_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("osc en", 1, osc_enable_o);
    chk("osc byp", 0, osc_bypass_o);
    oscillator_select_pin_i <= 1'b0;
  endtask
  // Two-wire writes land in the buffer until the strobe
  task automatic t_update;
    int ta, tf, s0;
    ta = 0;
    tf = 0;
    s0 = sro_cnt;
    host_u.frame(8'h00, 8'ha5, 1'b0, 1'b0, r, d);
    host_u.frame(8'h01, 8'h3c, 1'b0, 1'b0, r, d);
    host_u.frame(8'h81, 8'h00, 1'b0, 1'b0, r, d);
    chk("rd two-wire", 8'h3c, r);
    chk("pin drive", 1, d);
    chk("sro unused", s0, sro_cnt);
    chk("held", 0, amp_word_o);
    pace();
    io_update_i <= 1'b1;
    for (int n = 1; n < 60 && tf == 0; n++) begin
      @(posedge clk_i);
      if (ta == 0 && amp_word_o !== 8'h00) ta = n;
      if (freq_word_o !== 8'h00) tf = n;
    end
    pace();
    io_update_i <= 1'b0;
    chk("amp", 8'ha5, amp_word_o);
    chk("freq", 8'h3c, freq_word_o);
    chk("lag", FREQ_LAT_CYC - AMP_LAT_CYC, tf - ta);
    chk("amp lat", 1, ta > AMP_LAT_CYC && ta < AMP_LAT_CYC + 6);
    wb(1'b0, OFS_ACTIVE_LO, 0);
    chk("active", 32'h3ca5, wb_q);
  endtask
  // Three-wire, LSB first, profile change as update, abort
  task automatic t_three;
    wb(1'b1, OFS_CTRL, 32'h3);
    host_u.frame(8'h02, 8'h1e, 1'b1, 1'b1, r, d);
    host_u.frame(8'h82, 8'h00, 1'b1, 1'b1, r, d);
    chk("rd three-wire", 8'h1e, r);
    chk("pin input", 0, d);
    pace();
    profile_select_lo_i <= 1'b1;
    for (int n = 0; n < 60 && freq_word_o !== 8'h1e; n++) @(posedge clk_i);
    chk("prof freq", 8'h1e, freq_word_o);
    chk("profile", 1, profile_o);
    fork
      host_u.frame(8'h00, 8'hff, 1'b1, 1'b1, r, d);
      begin
        repeat (40) @(posedge clk_i);
        serial_port_abort_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        serial_port_abort_i <= 1'b0;
      end
    join
    host_u.frame(8'h80, 8'h00, 1'b1, 1'b1, r, d);
    chk("aborted", 8'ha5, r);
  endtask
  // Keying, power-down and alignment
  task automatic t_misc;
    logic p;
    int n;
    int f;
    wb(1'b1, OFS_CTRL, 32'h14);
    keying_direction_i <= 1'b1;
    ext_powerdown_pin_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("key", 1, keying_dir_o);
    chk("pd", 2, powerdown_o);
    wb(1'b0, OFS_STATUS, 0);
    chk("status", 32'h19, wb_q);
    keying_direction_i <= 1'b0;
    ext_powerdown_pin_i <= 1'b0;
    sync_align_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sync_align_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    p = sync_clk_o;
    n = 0;
    f = 0;
    // Align resets the divider, so the first rise lands at a fixed edge
    for (int k = 1; k <= 40; k++) begin
      @(posedge clk_i);
      if (sync_clk_o === 1'b1 && p === 1'b0) begin
        n++;
        if (f == 0) f = k;
      end
      p = sync_clk_o;
    end
    chk("pace rises", 10, n);
    chk("align phase", 2, f);
    // Mid-run reset must clear what earlier scenarios loaded
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("rst amp", 0, amp_word_o);
    wb(1'b0, OFS_ACTIVE_LO, 0);
    chk("rst active", 0, wb_q);
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_update();
    t_three();
    t_misc();
    report_and_stop();
  end
endmodule

// ==== test/host_model.sv ====
// Host side of the serial port, eight core clocks per link bit.
// Assumes clk_i is the core clock; link clock is still between frames.
`timescale 1ns/1ps
module host_model (
  // Core clock
  input wire logic clk_i,
  // Serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sd_o,
  output logic sd_en_o,
  input wire logic sd_i,
  input wire logic sro_i,
  input wire logic oe_n_i
);
  // Idle link: clock low, unselected, data released
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sd_o = 1'b0;
    sd_en_o = 1'b0;
  end
  ////////////////////////////////////////
  // One frame; read bits sampled late in the high phase, well settled
  task automatic frame(input logic [7:0] ins, input logic [7:0] dat, input logic lsb,
    input logic three, output logic [7:0] rd, output logic drv);
    int b;
    rd = 8'h00;
    drv = 1'b0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      b = lsb ? i % 8 : 7 - i % 8;
      sd_en_o <= !(ins[7] && i > 7);
      sd_o <= (i > 7) ? dat[b] : ins[b];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      if (i > 7) begin
        rd[b] = three ? sro_i : sd_i;
        drv = drv | !oe_n_i;
      end
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sd_en_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
endmodule
